// *** pkg/ssc_pkg.sv ***
// Package: constants and types of the sensor SPI command slave
package ssc_pkg;

    localparam int CLK_PERIOD_NS  = 100;
    localparam int RELOAD_TIME_US = 150;
    localparam int RELOAD_CYC     = (RELOAD_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int TICK_W         = 11;
    localparam logic [TICK_W-1:0] RELOAD_LAST = TICK_W'(RELOAD_CYC - 1);

    localparam int CMD_W      = 8;
    localparam int ACC_W      = 11;
    localparam int TEMP_W     = 8;
    localparam int TX_W       = 16;
    localparam int FIFO_DEPTH = 8;
    localparam logic [3:0] BIT_LAST = 4'h7;

    // Command codes, MSB first on the wire
    localparam logic [CMD_W-1:0] NORMAL_RUN_CMD      = 8'h00;
    localparam logic [CMD_W-1:0] TEMP_READ_WRITE_CMD = 8'h08;
    localparam logic [CMD_W-1:0] SELFTEST_X_CMD      = 8'h0E;
    localparam logic [CMD_W-1:0] SELFTEST_Y_CMD      = 8'h0F;
    localparam logic [CMD_W-1:0] ACCEL_X_READ_CMD    = 8'h10;
    localparam logic [CMD_W-1:0] ACCEL_Y_READ_CMD    = 8'h11;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_CMD,
        PH_DATA,
        PH_BLOCK
    } ssc_phase_t;

    // One received write byte with the command that carried it
    typedef struct packed {
        logic [CMD_W-1:0]  cmd;
        logic [TEMP_W-1:0] data;
    } ssc_wr_t;

    typedef struct packed {
        logic              sel_s1;
        logic              sel_s2;
        logic              sel_s3;
        logic              sck_s1;
        logic              sck_s2;
        logic              sck_s3;
        logic              mosi_s1;
        logic              mosi_s2;
        ssc_phase_t        phase;
        logic [3:0]        bit_cnt;
        logic [CMD_W-1:0]  rx_sh;
        logic [CMD_W-1:0]  cmd;
        logic              wr_cmd;
        logic [TX_W-1:0]   tx_sh;
        logic              tx_on;
        logic              drive;
        logic              miso;
        logic              st_x;
        logic              st_y;
        logic [ACC_W-1:0]  hold_x;
        logic [ACC_W-1:0]  hold_y;
        logic [TEMP_W-1:0] hold_t;
        logic [TICK_W-1:0] tick;
        logic              push;
        ssc_wr_t           push_word;
        logic              overrun;
    } ssc_state_t;

    // Selects idle high; self tests off, i.e. normal run mode
    localparam ssc_state_t SSC_STATE_RST = '{
        sel_s1  : 1'b1,
        sel_s2  : 1'b1,
        sel_s3  : 1'b1,
        phase   : PH_IDLE,
        default : '0
    };

endpackage

// *** hw/ssc_fifo.sv ***
// FIFO with a registered output stage for received write bytes
`timescale 1ns/1ps
module ssc_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    // DEPTH must be a power of two so the pointers wrap by themselves
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr_ptr;
        logic [AW-1:0]           rd_ptr;
        logic [AW:0]             count;
        logic                    out_valid;
        logic [W-1:0]            out_data;
    } ssc_fifo_state_t;

    ssc_fifo_state_t st_reg;
    ssc_fifo_state_t st_next;
    logic            push;
    logic            pop;

    assign in_ready  = (st_reg.count != (AW+1)'(DEPTH));
    assign push      = in_valid && in_ready;
    assign pop       = (st_reg.count != '0) && (!st_reg.out_valid || out_ready);
    assign out_valid = st_reg.out_valid;
    assign out_data  = st_reg.out_data;

    always_comb begin
        st_next = st_reg;
        if (st_reg.out_valid && out_ready) begin
            st_next.out_valid = 1'b0;
        end
        if (pop) begin
            st_next.out_valid = 1'b1;
            st_next.out_data  = st_reg.mem[st_reg.rd_ptr];
            st_next.rd_ptr    = st_reg.rd_ptr + 1'b1;
        end
        if (push) begin
            st_next.mem[st_reg.wr_ptr] = in_data;
            st_next.wr_ptr             = st_reg.wr_ptr + 1'b1;
        end
        st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

// *** hw/ssc_slave.sv ***
// SPI command slave of a two-axis accelerometer, oversampling the link
`timescale 1ns/1ps
module ssc_slave
    import ssc_pkg::*;
#(
    parameter bit TWO_AXIS = 1'b1,
    parameter int WR_DEPTH = FIFO_DEPTH
) (
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    input  wire logic              select_n,
    input  wire logic              sck,
    input  wire logic              mosi,
    output logic                   miso_o,
    output logic                   miso_oe,
    input  wire logic [ACC_W-1:0]  accel_x,
    input  wire logic [ACC_W-1:0]  accel_y,
    input  wire logic [TEMP_W-1:0] temp_in,
    input  wire logic              lock_open,
    output logic                   selftest_x,
    output logic                   selftest_y,
    output logic                   measure_mode,
    output logic                   wr_valid,
    input  wire logic              wr_ready,
    output ssc_wr_t                wr_data,
    output logic                   overrun
);

    ////////////////////////////////////////////////////////////////////////
    // Edge detection on the synchronised pins

    ssc_state_t       st_reg;
    ssc_state_t       st_next;
    logic             sel_rise;
    logic             sel_fall;
    logic             sel_steady;
    logic             sck_rise;
    logic             sck_fall;
    logic             reload;
    logic [CMD_W-1:0] rx_next;
    logic             cmd_done;
    logic             cmd_unk;
    logic             fifo_ready;

    // Only the second and third stages are looked at
    assign sel_rise   = st_reg.sel_s2 && !st_reg.sel_s3;
    assign sel_fall   = !st_reg.sel_s2 && st_reg.sel_s3;
    assign sel_steady = (st_reg.sel_s2 == st_reg.sel_s3);
    assign sck_rise   = st_reg.sck_s2 && !st_reg.sck_s3;
    assign sck_fall   = !st_reg.sck_s2 && st_reg.sck_s3;
    assign reload     = (st_reg.tick == RELOAD_LAST);
    assign rx_next    = {st_reg.rx_sh[CMD_W-2:0], st_reg.mosi_s2};
    assign cmd_done   = sel_steady && sck_rise && (st_reg.phase == PH_CMD)
                        && (st_reg.bit_cnt == BIT_LAST);
    assign cmd_unk    = !(rx_next inside {NORMAL_RUN_CMD, TEMP_READ_WRITE_CMD,
                                          SELFTEST_X_CMD, SELFTEST_Y_CMD,
                                          ACCEL_X_READ_CMD, ACCEL_Y_READ_CMD});

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next         = st_reg;
        st_next.sel_s1  = select_n;
        st_next.sel_s2  = st_reg.sel_s1;
        st_next.sel_s3  = st_reg.sel_s2;
        st_next.sck_s1  = sck;
        st_next.sck_s2  = st_reg.sck_s1;
        st_next.sck_s3  = st_reg.sck_s2;
        st_next.mosi_s1 = mosi;
        st_next.mosi_s2 = st_reg.mosi_s1;
        st_next.push    = 1'b0;

        // Free-running reload timer; holds freeze while the host selects
        if (reload) begin
            st_next.tick = '0;
        end else begin
            st_next.tick = st_reg.tick + 1'b1;
        end
        if (reload && st_reg.sel_s2) begin
            st_next.hold_x = accel_x;
            st_next.hold_y = accel_y;
            st_next.hold_t = temp_in;
        end

        if (sel_rise) begin
            st_next.phase   = PH_IDLE;
            st_next.bit_cnt = '0;
            st_next.cmd     = '0;
            st_next.rx_sh   = '0;
            st_next.wr_cmd  = 1'b0;
            st_next.tx_on   = 1'b0;
            st_next.drive   = 1'b0;
        end else if (sel_fall) begin
            st_next.phase   = PH_CMD;
            st_next.bit_cnt = '0;
            st_next.rx_sh   = '0;
            st_next.overrun = 1'b0;
        end else if (sck_rise) begin
            case (st_reg.phase)
                PH_CMD: begin
                    st_next.rx_sh   = rx_next;
                    st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
                    if (st_reg.bit_cnt == BIT_LAST) begin
                        st_next.bit_cnt = '0;
                        st_next.cmd     = rx_next;
                        st_next.phase   = PH_DATA;
                        case (rx_next)
                            NORMAL_RUN_CMD: begin
                                st_next.st_x = 1'b0;
                                st_next.st_y = 1'b0;
                            end
                            TEMP_READ_WRITE_CMD: begin
                                st_next.tx_sh  = {st_reg.hold_t,
                                                  {(TX_W-TEMP_W){1'b0}}};
                                st_next.tx_on  = 1'b1;
                                st_next.wr_cmd = 1'b1;
                            end
                            SELFTEST_X_CMD: begin
                                st_next.st_x = 1'b1;
                            end
                            SELFTEST_Y_CMD: begin
                                if (TWO_AXIS) begin
                                    st_next.st_y = 1'b1;
                                end else begin
                                    st_next.phase = PH_BLOCK;
                                end
                            end
                            ACCEL_X_READ_CMD: begin
                                st_next.tx_sh = {st_reg.hold_x,
                                                 {(TX_W-ACC_W){1'b0}}};
                                st_next.tx_on = 1'b1;
                            end
                            ACCEL_Y_READ_CMD: begin
                                if (TWO_AXIS) begin
                                    st_next.tx_sh = {st_reg.hold_y,
                                                     {(TX_W-ACC_W){1'b0}}};
                                    st_next.tx_on = 1'b1;
                                end else begin
                                    st_next.phase = PH_BLOCK;
                                end
                            end
                            default: begin
                                // Extra commands log their data bytes while lock_open is set, else block the frame
                                if (lock_open) begin
                                    st_next.wr_cmd = 1'b1;
                                end else begin
                                    st_next.phase = PH_BLOCK;
                                end
                            end
                        endcase
                    end
                end
                PH_DATA: begin
                    // Data bytes follow the command with no gap
                    if (st_reg.wr_cmd) begin
                        st_next.rx_sh   = rx_next;
                        st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
                        if (st_reg.bit_cnt == BIT_LAST) begin
                            st_next.bit_cnt        = '0;
                            st_next.push           = 1'b1;
                            st_next.push_word.cmd  = st_reg.cmd;
                            st_next.push_word.data = rx_next;
                        end
                    end
                end
                default: begin
                    // Idle and blocked frames take no input
                    st_next.bit_cnt = st_reg.bit_cnt;
                end
            endcase
        end else if (sck_fall && st_reg.tx_on) begin
            // After the last data bit zeros follow until select rises
            st_next.miso  = st_reg.tx_sh[TX_W-1];
            st_next.tx_sh = {st_reg.tx_sh[TX_W-2:0], 1'b0};
            st_next.drive = 1'b1;
        end

        // A byte lost to a full buffer is flagged; set beats frame clear
        if (st_reg.push && !fifo_ready) begin
            st_next.overrun = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= SSC_STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write byte buffer and outputs

    ssc_fifo #(
        .W     ($bits(ssc_wr_t)),
        .DEPTH (WR_DEPTH)
    ) u_wr_fifo (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .in_valid  (st_reg.push),
        .in_ready  (fifo_ready),
        .in_data   (st_reg.push_word),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_data)
    );

    assign miso_o       = st_reg.miso;
    assign miso_oe      = st_reg.drive;
    assign selftest_x   = st_reg.st_x;
    assign selftest_y   = st_reg.st_y;
    assign measure_mode = !st_reg.st_x && !st_reg.st_y;
    assign overrun      = st_reg.overrun;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    a_rx_shift_msb : assert property (
        sel_steady && sck_rise && st_reg.phase == PH_CMD
        |=> st_reg.rx_sh == {$past(st_reg.rx_sh[6:0]), $past(st_reg.mosi_s2)})
        else $error("command bit not shifted in on rising clock");

    a_tx_on_fall : assert property (
        sel_steady && sck_fall && st_reg.tx_on
        |=> miso_o == $past(st_reg.tx_sh[TX_W-1]) && miso_oe)
        else $error("output bit not taken from shift MSB on falling clock");

    a_miso_rise_hold : assert property (
        sck_rise |=> $stable(miso_o))
        else $error("output bit changed on rising clock");

    a_frame_clear : assert property (
        sel_rise
        |=> st_reg.bit_cnt == '0 && st_reg.cmd == '0 && st_reg.phase == PH_IDLE)
        else $error("select rise did not clear counter and command");

    a_block_quiet : assert property (
        st_reg.phase == PH_BLOCK |-> !miso_oe && !st_reg.push)
        else $error("blocked frame drove output or took data");

    a_lock_gate : assert property (
        cmd_done && cmd_unk && !lock_open |=> st_reg.phase == PH_BLOCK [*2])
        else $error("locked unknown command not blocked");

    a_first_drive : assert property (
        cmd_done && rx_next == ACCEL_X_READ_CMD |=> st_reg.tx_on && !miso_oe)
        else $error("read command did not arm the output shifter");

    a_drive_next_fall : assert property (
        st_reg.tx_on && !st_reg.drive && sel_steady && sck_fall
        |=> miso_oe && miso_o == $past(st_reg.tx_sh[TX_W-1]))
        else $error("first data bit not driven at next falling clock");

    a_duplex_count : assert property (
        sel_steady && sck_rise && st_reg.phase == PH_DATA && st_reg.wr_cmd
        |=> st_reg.bit_cnt != $past(st_reg.bit_cnt))
        else $error("write data not taken during read out");

    a_normal_run_cmd_ends_st : assert property (
        cmd_done && rx_next == NORMAL_RUN_CMD
        |=> !selftest_x && !selftest_y && measure_mode)
        else $error("normal run command left a self test active");

    a_stx_sets : assert property (
        cmd_done && rx_next == SELFTEST_X_CMD |=> selftest_x && !measure_mode)
        else $error("X self test not started");

    a_accel_x_read_cmd_data : assert property (
        cmd_done && rx_next == ACCEL_X_READ_CMD
        |=> st_reg.tx_sh[TX_W-1 -: ACC_W] == $past(st_reg.hold_x))
        else $error("X read did not load the held acceleration");

    a_accel_frozen : assert property (
        !st_reg.sel_s2 |=> $stable(st_reg.hold_x) && $stable(st_reg.hold_y))
        else $error("acceleration hold reloaded while selected");

    a_temp_frozen : assert property (
        !st_reg.sel_s2 |=> $stable(st_reg.hold_t))
        else $error("temperature hold reloaded while selected");

    a_temp_read_write_cmd_load : assert property (
        cmd_done && rx_next == TEMP_READ_WRITE_CMD
        |=> st_reg.tx_sh[TX_W-1 -: TEMP_W] == $past(st_reg.hold_t) && st_reg.wr_cmd)
        else $error("temperature command did not load read and write");

    a_single_axis : assert property (
        !TWO_AXIS |-> !selftest_y)
        else $error("Y self test active in single-axis build");

    a_idle_hiz : assert property (
        st_reg.sel_s2 && st_reg.sel_s3 |-> !miso_oe)
        else $error("output driven while deselected");

    a_miso_fall_only : assert property (
        !sck_fall |=> $stable(miso_o))
        else $error("output bit changed away from a falling clock");

    a_cmd_quiet : assert property (
        st_reg.phase == PH_CMD |-> !miso_oe)
        else $error("output driven during command reception");

    a_unk_no_load : assert property (
        cmd_done && cmd_unk && !lock_open |=> !st_reg.wr_cmd && !st_reg.tx_on)
        else $error("locked unknown command armed a transfer");

    // Sticky loss flag must survive a frame start in the same cycle
    a_overrun_sets : assert property (
        st_reg.push && !fifo_ready |=> overrun)
        else $error("lost write byte not flagged");

    c_accel_read : cover property (
        cmd_done && rx_next == ACCEL_X_READ_CMD ##[1:200] miso_oe);
    c_lost_byte : cover property (st_reg.push && !fifo_ready);
    c_temp_byte : cover property (st_reg.push && st_reg.push_word.cmd == TEMP_READ_WRITE_CMD);
    c_blocked : cover property (st_reg.phase == PH_BLOCK ##1 sel_fall);
    c_selftest : cover property (selftest_x ##1 !selftest_x);

endmodule

// *** test/ssc_host_model.sv ***
// Host-side SPI master model that drives the sensor link
`timescale 1ns/1ps
module ssc_host_model (
    output logic      select_n,
    output logic      sck,
    output logic      mosi,
    input  wire logic miso_o,
    input  wire logic miso_oe
);
    // Faster than a real host may clock: the oversampler needs three reference
    // clocks per phase, and the short period keeps the run brief
    localparam int HALF_NS = 400;
    localparam int GAP_NS  = 160_000;
    // Pin changes land away from rising reference clock edges
    localparam int SKEW_NS = 25;

    // Select pulled up, clock and data pulled down while idle
    initial begin
        select_n = 1'b1;
        sck      = 1'b0;
        mosi     = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Send n bits of v MSB first; log the returned bit and enable of each slot
    task automatic xfer(input logic [87:0] v, input int n,
                        output logic [87:0] rx, output logic [87:0] oe);
        rx = '0;
        oe = '0;
        #(GAP_NS + SKEW_NS);
        select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi = v[n-1-i];
            #(HALF_NS);
            sck = 1'b1;
            // Midway through the high phase, so slave synchroniser lag is covered
            #(HALF_NS / 2);
            rx[n-1-i] = miso_o;
            oe[n-1-i] = miso_oe;
            #(HALF_NS / 2);
            sck = 1'b0;
        end
        #(HALF_NS);
        select_n = 1'b1;
        mosi     = 1'b0;
    endtask
endmodule

// *** test/ssc_slave_tb.sv ***
// Self-checking bench of the sensor SPI command slave
`timescale 1ns/1ps
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t %s", $time, m); end end
module ssc_slave_tb
    import ssc_pkg::*;
();
    localparam logic [ACC_W-1:0]  ACC_Y  = 11'h2C6;
    localparam logic [TEMP_W-1:0] TEMP_V = 8'hB7;

    typedef struct {
        logic [7:0]  cmd;
        logic        lock;
        logic [10:0] ax;
        logic [15:0] rd;
        logic        oe;
        logic [1:0]  st;
        int          words;
    } ssc_row_t;

    logic             ref_clk;
    logic             reset_n;
    logic             select_n;
    logic             sck;
    logic             mosi;
    logic             miso_o;
    logic             miso_oe;
    logic             lock_open;
    logic             selftest_x;
    logic             selftest_y;
    logic             measure_mode;
    logic             wr_valid;
    logic             wr_ready;
    logic             overrun;
    logic [ACC_W-1:0] accel_x;
    logic             sa_oe;
    logic             sa_stx;
    logic             sa_sty;
    logic [7:0]       temp_in;
    int               sa_oe_cnt = 0;
    int               sa_base   = 0;
    logic [87:0]      rx;
    logic [87:0]      oe;
    ssc_wr_t          wr_data;
    ssc_wr_t          got_q[$];
    int               fails     = 0;
    int               cmp_count = 0;

    // Unknown code 8'h55 stands for a command outside the documented set
    ssc_row_t rows[10] = '{
        '{8'h10, 1'b0, 11'h5A3, {11'h5A3, 5'h00}, 1'b1, 2'b00, 0},
        '{8'h11, 1'b0, 11'h5A3, {ACC_Y, 5'h00},   1'b1, 2'b00, 0},
        '{8'h08, 1'b0, 11'h5A3, {TEMP_V, 8'h00},  1'b1, 2'b00, 2},
        '{8'h0E, 1'b0, 11'h5A3, 16'h0000,         1'b0, 2'b01, 0},
        '{8'h0F, 1'b0, 11'h5A3, 16'h0000,         1'b0, 2'b11, 0},
        '{8'h00, 1'b0, 11'h5A3, 16'h0000,         1'b0, 2'b00, 0},
        '{8'h55, 1'b0, 11'h5A3, 16'h0000,         1'b0, 2'b00, 0},
        '{8'h55, 1'b1, 11'h5A3, 16'h0000,         1'b0, 2'b00, 2},
        '{8'h10, 1'b0, 11'h7FF, {11'h7FF, 5'h00}, 1'b1, 2'b00, 0},
        '{8'h10, 1'b0, 11'h001, {11'h001, 5'h00}, 1'b1, 2'b00, 0}
    };

    ssc_slave #(.TWO_AXIS(1'b1), .WR_DEPTH(8)) dut_u (
        .ref_clk(ref_clk), .reset_n(reset_n), .select_n(select_n), .sck(sck),
        .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .accel_x(accel_x),
        .accel_y(ACC_Y), .temp_in(temp_in), .lock_open(lock_open),
        .selftest_x(selftest_x), .selftest_y(selftest_y), .measure_mode(measure_mode),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .overrun(overrun)
    );

    // Single-axis build on the same link; only its drive and self tests are watched
    ssc_slave #(.TWO_AXIS(1'b0), .WR_DEPTH(8)) dut_one_u (
        .ref_clk(ref_clk), .reset_n(reset_n), .select_n(select_n), .sck(sck),
        .mosi(mosi), .miso_o(), .miso_oe(sa_oe), .accel_x(accel_x),
        .accel_y(ACC_Y), .temp_in(temp_in), .lock_open(lock_open),
        .selftest_x(sa_stx), .selftest_y(sa_sty), .measure_mode(),
        .wr_valid(), .wr_ready(1'b1), .wr_data(), .overrun()
    );

    ssc_host_model host_u (
        .select_n(select_n), .sck(sck), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe)
    );

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            got_q.push_back(wr_data);
        end
        if (sa_oe === 1'b1) begin
            sa_oe_cnt++;
        end
    end

    task automatic give_verdict();
        if (fails == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Run takes about 3 ms of link traffic
    initial begin
        #(6_000_000);
        fails++;
        give_verdict();
    end

    initial begin
        reset_n   = 1'b0;
        accel_x   = 11'h5A3;
        temp_in   = TEMP_V;
        lock_open = 1'b0;
        wr_ready  = 1'b1;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK({miso_oe, wr_valid, overrun}, 3'b000, "reset outputs")
        `CHK({measure_mode, selftest_x, selftest_y}, 3'b100, "reset mode")
        for (int r = 0; r < 10; r++) begin
            @(posedge ref_clk);
            accel_x   <= rows[r].ax;
            lock_open <= rows[r].lock;
            got_q.delete();
            sa_base = sa_oe_cnt;
            host_u.xfer({64'h0, rows[r].cmd, 16'hA53C}, 24, rx, oe);
            repeat (10) @(posedge ref_clk);
            `CHK(oe[23:16], 8'h00, "driven in command")
            `CHK(oe[15:0], {16{rows[r].oe}}, "data enable")
            if (rows[r].oe) `CHK(rx[15:0], rows[r].rd, "read data")
            `CHK({selftest_y, selftest_x}, rows[r].st, "self test")
            `CHK(measure_mode, rows[r].st == 2'b00, "measure mode")
            `CHK(miso_oe, 1'b0, "not released")
            `CHK(got_q.size(), rows[r].words, "word count")
            `CHK(sa_oe_cnt != sa_base, rows[r].oe && rows[r].cmd != 8'h11, "one axis")
            `CHK({sa_sty, sa_stx}, {1'b0, rows[r].st[0]}, "axis self test")
            for (int k = 0; k < got_q.size() && k < 2; k++) begin
                `CHK(got_q[k], {rows[r].cmd, (k == 0) ? 8'hA5 : 8'h3C}, "word")
            end
        end
        // Abort inside a command; a stale count would garble the next one
        host_u.xfer({84'h0, 4'h1}, 4, rx, oe);
        host_u.xfer({80'h0, SELFTEST_X_CMD}, 8, rx, oe);
        repeat (10) @(posedge ref_clk);
        `CHK(selftest_x, 1'b1, "select rise clear")
        // Stalled consumer: nine words fit, the tenth is lost
        @(posedge ref_clk);
        wr_ready <= 1'b0;
        got_q.delete();
        host_u.xfer({TEMP_READ_WRITE_CMD, 80'h0102_0304_0506_0708_090A}, 88, rx, oe);
        repeat (10) @(posedge ref_clk);
        `CHK(rx[79:64], {TEMP_V, 8'h00}, "temp data")
        `CHK({overrun, wr_valid}, 2'b11, "overrun")
        @(posedge ref_clk);
        wr_ready <= 1'b1;
        repeat (20) @(posedge ref_clk);
        `CHK(got_q.size(), 9, "kept words")
        `CHK(got_q[8], {TEMP_READ_WRITE_CMD, 8'h09}, "last word")
        `CHK(wr_valid, 1'b0, "drained")
        host_u.xfer({80'h0, NORMAL_RUN_CMD}, 8, rx, oe);
        repeat (10) @(posedge ref_clk);
        `CHK({overrun, selftest_x, measure_mode}, 3'b001, "normal run")
        // Fresh temperature value, zero write bytes as a host should send
        @(posedge ref_clk);
        temp_in <= 8'h4E;
        got_q.delete();
        host_u.xfer({64'h0, TEMP_READ_WRITE_CMD, 16'h0000}, 24, rx, oe);
        repeat (10) @(posedge ref_clk);
        `CHK(rx[15:0], {8'h4E, 8'h00}, "fresh temp data")
        `CHK(got_q.size(), 2, "zero write count")
        `CHK(got_q[1], {TEMP_READ_WRITE_CMD, 8'h00}, "zero write word")
        give_verdict();
    end
endmodule
